// ### rtl/asfdi_core.sv
// module: converter result queue with pacing request and interrupt
`timescale 1ns/1ps
// ==========================================================
// Notes on behaviour
// - four-entry sample queue plus the latest result always in result_value
// - fifo_enable set pushes each completed conversion the queue has room for; clear pushes none
// - queue is disabled after reset
// - push into full queue without a simultaneous pop sets overflow_flag and drops the new result
// - byte shift stores result bits 11:4 in queue bits 7:0
// - fault_tag_enable tags each queued sample with its conversion fault
// - consumer reads the queue paced by dma_pace_request driven here
// - pacing request only while dma_request_enable is set
// - one fifo_threshold qualifies both pacing request and interrupt
// - channel_scan_mask has five channel bits; input_select names first
// - a start select not in the scan mask is accepted, no error
// - interrupt at level reaching threshold, gated by irq_enable_reg
// - interrupt is a level, cleared by draining below threshold, raising fifo_threshold or clearing irq_enable_reg
// - temperature channel is select 4 and needs temp_bias_enable
// - request and raw interrupt when level >= threshold field
// - overflow and underflow stay set until a one is written
// - queue word: value bits 11:0, fault tag bit 15 even when shifted
module asfdi_core
  import asfdi_pkg::*;
(
  input  wire logic                    clock,
  input  wire logic                    nrst,
  input  wire logic                    conv_done,
  input  wire logic [ASFDI_RES_W-1:0]  conv_result,
  input  wire logic                    conv_fault,
  input  wire logic                    fifo_enable,
  input  wire logic                    byte_shift_option,
  input  wire logic                    fault_tag_enable,
  input  wire logic                    dma_request_enable,
  input  wire logic [ASFDI_THR_W-1:0]  fifo_threshold,
  input  wire logic                    irq_enable_reg,
  input  wire logic                    overflow_clear,
  input  wire logic                    underflow_clear,
  input  wire logic                    queue_read,
  input  wire logic [ASFDI_MASK_W-1:0] channel_scan_mask,
  input  wire logic [ASFDI_SEL_W-1:0]  input_select_init,
  input  wire logic                    input_select_load,
  input  wire logic                    temp_bias_enable,
  output logic [ASFDI_RES_W-1:0]       result_value,
  output logic [ASFDI_WORD_W-1:0]      queue_data,
  output logic [ASFDI_LVL_W-1:0]       fifo_level,
  output logic                         fifo_full,
  output logic                         fifo_empty,
  output logic                         overflow_flag,
  output logic                         underflow_flag,
  output logic                         dma_pace_request,
  output logic                         irq_raw,
  output logic                         irq_status_masked,
  output logic                         irq_out,
  output logic [ASFDI_SEL_W-1:0]       input_select,
  output logic                         temp_bias_on
);

  // ==========================================================
  // storage and pointers
  logic [ASFDI_WORD_W-1:0] mem_reg [ASFDI_DEPTH];
  logic [ASFDI_PTR_W-1:0]  wr_ptr_reg;
  logic [ASFDI_PTR_W-1:0]  rd_ptr_reg;
  logic [ASFDI_LVL_W-1:0]  level_reg;
  logic [ASFDI_LVL_W-1:0]  level_next;
  logic [ASFDI_WORD_W-1:0] push_word;
  logic [ASFDI_WORD_W-1:0] data_reg;
  logic                    over_reg;
  logic                    under_reg;
  logic [ASFDI_RES_W-1:0]  result_reg;
  logic [ASFDI_SEL_W-1:0]  sel_reg;
  logic [ASFDI_SEL_W-1:0]  sel_next;
  logic                    full_w;
  logic                    empty_w;
  logic                    push_try;
  logic                    push_ok;
  logic                    pop_ok;
  logic                    at_thr;

  // ==========================================================
  // next values and strobes
  logic [ASFDI_PTR_W-1:0]  wr_ptr_next;
  logic [ASFDI_PTR_W-1:0]  rd_ptr_next;
  logic [ASFDI_WORD_W-1:0] data_next;
  logic [ASFDI_WORD_W-1:0] pop_word;
  logic [ASFDI_RES_W-1:0]  result_next;
  logic                    over_next;
  logic                    under_next;
  logic                    over_set;
  logic                    under_set;
  logic                    scan_on;

  assign full_w   = (level_reg == ASFDI_LVL_FULL);
  assign empty_w  = (level_reg == '0);
  assign push_try = conv_done && fifo_enable;
  assign pop_ok   = queue_read && !empty_w;
  // a simultaneous pop frees the slot for the push
  assign push_ok  = push_try && (!full_w || pop_ok);
  // pop side reads the oldest slot
  assign pop_word = mem_reg[rd_ptr_reg];
  // mask of zero stops the scan
  assign scan_on  = (channel_scan_mask != '0);

  // ==========================================================
  // sample word formation
  always_comb begin
    push_word = ASFDI_WORD_RST;
    if (byte_shift_option) begin
      push_word[ASFDI_BYTE_W-1:0] =
        conv_result[ASFDI_RES_W-1:ASFDI_SHIFT_LSB];
    end else begin
      push_word[ASFDI_RES_W-1:0] = conv_result;
    end
    push_word[ASFDI_TAG_BIT] = fault_tag_enable && conv_fault;
  end

  // ==========================================================
  // latest result, always updated
  always_comb begin
    result_next = result_reg;
    if (conv_done) begin
      result_next = conv_result;
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      result_reg <= ASFDI_RES_RST;
    end else begin
      result_reg <= result_next;
    end
  end

  // ==========================================================
  // queue storage
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      for (int i = 0; i < ASFDI_DEPTH; i++) begin
        mem_reg[i] <= ASFDI_WORD_RST;
      end
    end else if (push_ok) begin
      mem_reg[wr_ptr_reg] <= push_word;
    end
  end

  // ==========================================================
  // write and read pointers
  always_comb begin
    wr_ptr_next = wr_ptr_reg;
    if (push_ok) begin
      wr_ptr_next = wr_ptr_reg + 1'b1;
    end
  end

  always_comb begin
    rd_ptr_next = rd_ptr_reg;
    if (pop_ok) begin
      rd_ptr_next = rd_ptr_reg + 1'b1;
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      wr_ptr_reg <= '0;
    end else begin
      wr_ptr_reg <= wr_ptr_next;
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      rd_ptr_reg <= '0;
    end else begin
      rd_ptr_reg <= rd_ptr_next;
    end
  end

  // ==========================================================
  // fill level
  always_comb begin
    level_next = level_reg;
    if (push_ok && !pop_ok) begin
      level_next = level_reg + ASFDI_LVL_ONE;
    end else if (pop_ok && !push_ok) begin
      level_next = level_reg - ASFDI_LVL_ONE;
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      level_reg <= '0;
    end else begin
      level_reg <= level_next;
    end
  end

  // ==========================================================
  // read data captured on the pop edge
  always_comb begin
    data_next = data_reg;
    if (pop_ok) begin
      data_next = pop_word;
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      data_reg <= ASFDI_WORD_RST;
    end else begin
      data_reg <= data_next;
    end
  end

  // ==========================================================
  // sticky error flags, set wins over clear
  assign over_set  = push_try && full_w && !pop_ok;
  assign under_set = queue_read && empty_w;

  always_comb begin
    over_next = over_reg;
    if (over_set) begin
      over_next = 1'b1;
    end else if (overflow_clear) begin
      over_next = 1'b0;
    end
  end

  always_comb begin
    under_next = under_reg;
    if (under_set) begin
      under_next = 1'b1;
    end else if (underflow_clear) begin
      under_next = 1'b0;
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      over_reg <= 1'b0;
    end else begin
      over_reg <= over_next;
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      under_reg <= 1'b0;
    end else begin
      under_reg <= under_next;
    end
  end

  // ==========================================================
  // channel scan select
  always_comb begin
    sel_next = sel_reg;
    for (int k = ASFDI_MASK_W; k >= 1; k--) begin
      if (channel_scan_mask[(32'(sel_reg) + k) % ASFDI_MASK_W]) begin
        sel_next = ASFDI_SEL_W'((32'(sel_reg) + k) % ASFDI_MASK_W);
      end
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      sel_reg <= '0;
    end else if (input_select_load) begin
      sel_reg <= input_select_init;
    end else if (conv_done && scan_on) begin
      sel_reg <= sel_next;
    end
  end

  // ==========================================================
  // request and interrupt, plain levels
  assign at_thr = ({1'b0, level_reg} >= fifo_threshold);

  // ==========================================================
  // outputs
  assign result_value      = result_reg;
  assign queue_data        = data_reg;
  assign fifo_level        = level_reg;
  assign fifo_full         = full_w;
  assign fifo_empty        = empty_w;
  assign overflow_flag     = over_reg;
  assign underflow_flag    = under_reg;
  assign dma_pace_request  = at_thr && dma_request_enable;
  assign irq_raw           = at_thr;
  assign irq_status_masked = at_thr && irq_enable_reg;
  assign irq_out           = irq_status_masked;
  assign input_select      = sel_reg;
  assign temp_bias_on      = temp_bias_enable;

endmodule // asfdi_core

// ### rtl/asfdi_pkg.sv
// package: constants for the converter result queue block
package asfdi_pkg;
  localparam int          ASFDI_DEPTH      = 4;
  localparam int          ASFDI_PTR_W      = 2;
  localparam int          ASFDI_LVL_W      = 3;
  localparam int          ASFDI_RES_W      = 12;
  localparam int          ASFDI_WORD_W     = 16;
  localparam int          ASFDI_THR_W      = 4;
  localparam int          ASFDI_SEL_W      = 3;
  localparam int          ASFDI_MASK_W     = 5;
  localparam int          ASFDI_TAG_BIT    = 15;
  localparam int          ASFDI_SHIFT_LSB  = 4;
  localparam int          ASFDI_BYTE_W     = 8;
  localparam int          ASFDI_THR_LSB    = 24;
  localparam logic [2:0]  ASFDI_TEMP_SEL   = 3'h4;
  localparam logic [2:0]  ASFDI_LVL_ONE    = 3'h1;
  localparam logic [2:0]  ASFDI_LVL_FULL   = 3'h4;
  localparam logic [11:0] ASFDI_RES_RST    = 12'h000;
  localparam logic [15:0] ASFDI_WORD_RST   = 16'h0000;
  localparam logic [3:0]  ASFDI_THR_RST    = 4'h0;
endpackage

// ### verification/asfdi_chk.sv
// checker: queue level, flag and request timing
`timescale 1ns/1ps
module asfdi_chk
  import asfdi_pkg::*;
(
  input wire logic                   clock,
  input wire logic                   nrst,
  input wire logic                   conv_done,
  input wire logic                   fifo_enable,
  input wire logic                   queue_read,
  input wire logic                   dma_request_enable,
  input wire logic                   irq_enable_reg,
  input wire logic                   overflow_clear,
  input wire logic                   underflow_clear,
  input wire logic [ASFDI_THR_W-1:0] fifo_threshold,
  input wire logic [ASFDI_LVL_W-1:0] fifo_level,
  input wire logic                   fifo_full,
  input wire logic                   fifo_empty,
  input wire logic                   overflow_flag,
  input wire logic                   underflow_flag,
  input wire logic                   dma_pace_request,
  input wire logic                   irq_raw,
  input wire logic                   irq_status_masked,
  input wire logic                   irq_out
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!nrst);
  // ====================
  // assertions
  property p_push; conv_done && fifo_enable && !fifo_full && !queue_read
    |=> fifo_level == $past(fifo_level) + 3'h1; endproperty
  a_push: assert property (p_push) else $error("push level");
  property p_ovf; conv_done && fifo_enable && fifo_full && !queue_read
    |=> overflow_flag && fifo_full; endproperty
  a_ovf: assert property (p_ovf) else $error("overflow");
  property p_off; !fifo_enable && !queue_read |=> $stable(fifo_level);
  endproperty
  a_off: assert property (p_off) else $error("push while off");
  property p_pop; queue_read && !fifo_empty && !conv_done
    |=> fifo_level == $past(fifo_level) - 3'h1; endproperty
  a_pop: assert property (p_pop) else $error("pop level");
  property p_unf; queue_read && fifo_empty && !conv_done
    |=> underflow_flag && fifo_empty; endproperty
  a_unf: assert property (p_unf) else $error("underflow");
  property p_keep; overflow_flag && !overflow_clear |=> overflow_flag;
  endproperty
  a_keep: assert property (p_keep) else $error("flag lost");
  property p_ukeep; underflow_flag && !underflow_clear |=> underflow_flag;
  endproperty
  a_ukeep: assert property (p_ukeep) else $error("under lost");
  property p_dreq; dma_pace_request == (dma_request_enable
    && {1'b0, fifo_level} >= fifo_threshold); endproperty
  a_dreq: assert property (p_dreq) else $error("pacing");
  property p_raw; irq_raw == ({1'b0, fifo_level} >= fifo_threshold);
  endproperty
  a_raw: assert property (p_raw) else $error("raw irq");
  property p_irq; irq_out == (irq_raw && irq_enable_reg)
    && irq_status_masked == irq_out; endproperty
  a_irq: assert property (p_irq) else $error("irq gate");
  c_ovf: cover property (overflow_flag);
  c_pace: cover property (dma_pace_request && queue_read);
  c_unf: cover property (underflow_flag);
  c_irq: cover property (irq_out);
endmodule // asfdi_chk
bind asfdi_core asfdi_chk u_chk (.*);

// ### verification/asfdi_consumer.sv
// partner: paced consumer reading the queue on request
`timescale 1ns/1ps
module asfdi_consumer
  import asfdi_pkg::*;
(
  input  wire logic                    clock,
  input  wire logic                    nrst,
  input  wire logic                    go,
  input  wire logic                    dma_pace_request,
  input  wire logic [ASFDI_WORD_W-1:0] queue_data,
  output logic                         rd,
  output logic [3:0]                   n_good,
  output logic [ASFDI_WORD_W-1:0]      last_word
);
  logic rd_d;
  // ====================
  // reads paced by the request
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      rd <= 1'b0;
      rd_d <= 1'b0;
      n_good <= 4'h0;
      last_word <= 16'h0000;
    end else begin
      rd <= go && dma_pace_request && !rd;
      rd_d <= rd;
      if (rd_d && !queue_data[ASFDI_TAG_BIT]) begin
        n_good <= n_good + 4'h1;
        last_word <= queue_data;
      end
    end
  end
endmodule // asfdi_consumer

// ### verification/adc_sample_fifo_dma_irq_bench.sv
// bench: directed scenarios for the converter result queue
`timescale 1ns/1ps
module adc_sample_fifo_dma_irq_bench;
  import asfdi_pkg::*;
  logic        clock = 1'b0, nrst = 1'b0, done = 1'b0, fault = 1'b0;
  logic        en = 1'b0, shift = 1'b0, tag = 1'b0, dq_en = 1'b0;
  logic        ie = 1'b0, oclr = 1'b0, uclr = 1'b0, brd = 1'b0;
  logic        load = 1'b0, ts = 1'b0, go = 1'b0;
  logic [11:0] res = 12'h000, rv;
  logic [3:0]  thr = 4'h0, n_good;
  logic [4:0]  mask = 5'h00;
  logic [2:0]  sel0 = 3'h0, lvl, sel;
  logic [15:0] qd, last_w;
  logic        full, empty, ovf, unf, dreq, raw, ims, irq, ts_on, drd;
  int          fails = 0, n_compared = 0;
  always #12.5 clock = ~clock;
  asfdi_core u_dut (.clock(clock), .nrst(nrst), .conv_done(done),
    .conv_result(res), .conv_fault(fault), .fifo_enable(en),
    .byte_shift_option(shift), .fault_tag_enable(tag),
    .dma_request_enable(dq_en), .fifo_threshold(thr), .irq_enable_reg(ie),
    .overflow_clear(oclr), .underflow_clear(uclr), .queue_read(brd | drd),
    .channel_scan_mask(mask), .input_select_init(sel0),
    .input_select_load(load), .temp_bias_enable(ts), .result_value(rv),
    .queue_data(qd), .fifo_level(lvl), .fifo_full(full), .fifo_empty(empty),
    .overflow_flag(ovf), .underflow_flag(unf), .dma_pace_request(dreq),
    .irq_raw(raw), .irq_status_masked(ims), .irq_out(irq),
    .input_select(sel), .temp_bias_on(ts_on));
  asfdi_consumer u_dma (.clock(clock), .nrst(nrst), .go(go),
    .dma_pace_request(dreq), .queue_data(qd), .rd(drd), .n_good(n_good),
    .last_word(last_w));
  // ====================
  // shared tasks
  task automatic chk(input string nm, input logic [15:0] e, g);
    #1;
    n_compared++;
    if (g !== e) begin
      fails++;
      $display("unexpected %s: expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic summarize;
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic pulse(ref logic s);
    @(negedge clock);
    s = 1'b1;
    @(negedge clock);
    s = 1'b0;
  endtask
  task automatic push(input logic [11:0] r, input logic f);
    res = r;
    fault = f;
    pulse(done);
  endtask
  task automatic shape(input logic s, t, input logic [15:0] e);
    shift = s;
    tag = t;
    push(12'hABC, 1'b1);
    pulse(brd);
    chk("word", e, qd);
  endtask
  // ====================
  // scenarios
  task automatic t_fill;
    push(12'h123, 1'b0);
    chk("level", 3'h0, lvl);
    chk("result", 12'h123, rv);
    en = 1'b1;
    for (int i = 0; i < 5; i++) push(12'(12'h100 + i), 1'b0);
    chk("full", {1'b0, 1'b1, 3'h4}, {empty, full, lvl});
    chk("ovf", 1'b1, ovf);
    for (int i = 0; i < 4; i++) begin
      pulse(brd);
      chk("data", 16'(16'h0100 + i), qd);
    end
    pulse(brd);
    chk("unf", 1'b1, unf);
    chk("held", 16'h0103, qd);
    chk("empty", {1'b1, 3'h0}, {empty, lvl});
    chk("ovf", 1'b1, ovf);
    pulse(oclr);
    pulse(uclr);
    chk("flags", 2'b00, {ovf, unf});
  endtask
  task automatic t_irq;
    thr = 4'h2;
    push(12'h001, 1'b0);
    push(12'h002, 1'b0);
    chk("gated", 4'h8, {raw, irq, ims, dreq});
    ie = 1'b1;
    dq_en = 1'b1;
    #1;
    chk("irq", 3'h7, {irq, ims, dreq});
    pulse(oclr);
    chk("irq", 1'b1, irq);
    thr = 4'h3;
    #1;
    chk("above", 2'b00, {raw, dreq});
    thr = 4'h2;
    pulse(brd);
    chk("drain", 2'b00, {irq, dreq});
    pulse(brd);
    dq_en = 1'b0;
  endtask
  task automatic t_stream;
    thr = 4'h1;
    dq_en = 1'b1;
    go = 1'b1;
    shift = 1'b1;
    tag = 1'b1;
    push(12'h5A0, 1'b0);
    push(12'h777, 1'b1);
    push(12'hC3F, 1'b0);
    for (int i = 0; i < 40 && empty !== 1'b1; i++) begin
      @(negedge clock);
    end
    if (empty !== 1'b1) begin
      fails++;
      summarize;
    end
    repeat (3) @(negedge clock);
    chk("good", 4'h2, n_good);
    chk("last", 16'h00C3, last_w);
    go = 1'b0;
  endtask
  task automatic t_scan;
    logic [2:0] seq [3] = '{3'h1, 3'h2, 3'h1};
    en = 1'b0;
    mask = 5'h06;
    pulse(load);
    chk("sel", 3'h0, sel);
    for (int i = 0; i < 3; i++) begin
      push(12'h000, 1'b0);
      chk("scan", seq[i], sel);
    end
    mask = 5'h11;
    sel0 = ASFDI_TEMP_SEL;
    ts = 1'b1;
    pulse(load);
    chk("temp", 4'hC, {ts_on, sel});
    push(12'h000, 1'b0);
    chk("wrap", 3'h0, sel);
  endtask
  initial begin
    repeat (3) @(negedge clock);
    nrst = 1'b1;
    t_fill;
    shape(1'b1, 1'b1, 16'h80AB);
    shape(1'b0, 1'b1, 16'h8ABC);
    shape(1'b0, 1'b0, 16'h0ABC);
    t_irq;
    t_stream;
    t_scan;
    summarize;
  end
endmodule // adc_sample_fifo_dma_irq_bench
